// >>> design/mpdc_config_regs.sv
`timescale 1ns/1ps
module mpdc_config_regs
  import mpdc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic overtemp_warning,
  input wire logic [7:0] duty_cmd,
  input wire logic at_open_to_closed_speed,
  output logic [5:0] current_limit,
  output logic soft_limit_active,
  output logic [5:0] lock_current_threshold,
  output logic [5:0] lock_detect_en,
  output logic speed_input_type,
  output logic [5:0] output_pwm_khz,
  output logic [2:0] kt_high_q,
  output logic [3:0] kt_high_wide,
  output logic [2:0] kt_low_q,
  output logic inductive_surge_guard_en,
  output logic mechanical_surge_guard_en,
  output logic mechanical_surge_reference,
  output mpdc_pkg::mpdc_release_t sense_release_behaviour,
  output logic enter_closed_loop,
  output logic [2:0] closed_loop_acceleration,
  output logic [7:0] duty_out,
  output logic [6:0] phase_edge_speed
);
  import mpdc_pkg::*;

  typedef struct packed {
    logic [15:0] prot;
    logic [15:0] drive;
    logic [15:0] rdata;
    logic rvalid;
    logic [5:0] cur_lim;
    logic soft_act;
    logic [5:0] lock_thr;
    logic [5:0] lock_en;
    logic spd_type;
    logic [5:0] pwm_khz;
    logic [2:0] kt_hi;
    logic [3:0] kt_hi_w;
    logic [2:0] kt_lo;
    logic ind_sg;
    logic mech_sg;
    logic mech_ref;
    mpdc_release_t rel;
    logic closed;
    logic [2:0] accel;
    logic [7:0] duty;
    logic [6:0] slew;
  } mpdc_state_t;

  mpdc_state_t st;
  mpdc_state_t next_st;
  logic [7:0] duty_calc;

  mpdc_duty_floor u_duty (
    .policy(st.drive[DUTY_POL_HI:DUTY_POL_LO]),
    .duty_cmd(duty_cmd),
    .duty_out(duty_calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [5:0] lock_thr_f(input logic [2:0] code,
                                            input logic range);
    logic [5:0] v;
    v = 6'h00;
    if (range) begin
      v = 6'((code + 4'h1) * CUR_STEP_LOCK);
    end else begin
      case (code[1:0])
        2'b00: v = LOCK_2A5;
        2'b01: v = LOCK_1A9;
        2'b10: v = LOCK_1A5;
        default: v = LOCK_0A9;
      endcase
    end
    return v;
  endfunction

  function automatic logic [6:0] slew_f(input logic [1:0] code);
    logic [6:0] v;
    v = SLEW_35;
    case (code)
      2'b00: v = SLEW_35;
      2'b01: v = SLEW_50;
      2'b10: v = SLEW_80;
      default: v = SLEW_120;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic [5:0] soft_val;
  logic [5:0] ot_val;
  always_comb begin
    next_st = st;
    next_st.rvalid = reg_rd;
    if (reg_wr && reg_addr == PROT_LIMIT_OFS) begin
      next_st.prot = reg_wdata;
    end
    if (reg_wr && reg_addr == DRIVE_MODE_OFS) begin
      next_st.drive = reg_wdata;
    end
    // reads return the stored value; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        PROT_LIMIT_OFS: next_st.rdata = st.prot;
        DRIVE_MODE_OFS: next_st.rdata = st.drive;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    soft_val = 6'(st.prot[SOFT_LIM_HI:SOFT_LIM_LO] * CUR_STEP_SOFT);
    case (st.prot[OT_CAP_HI:OT_CAP_LO])
      2'b01: ot_val = OT_CAP_1A;
      2'b10: ot_val = OT_CAP_1A6;
      2'b11: ot_val = OT_CAP_2A;
      default: ot_val = 6'h00;
    endcase
    // the overtemp cap only wins when it is tighter or no soft limit is set
    if (overtemp_warning && ot_val != 6'h00 &&
        (soft_val == 6'h00 || ot_val < soft_val)) begin
      next_st.cur_lim = ot_val;
    end else begin
      next_st.cur_lim = soft_val;
    end
    next_st.soft_act = soft_val != 6'h00;
    next_st.lock_thr = lock_thr_f(st.prot[LOCK_THR_HI:LOCK_THR_LO],
                                  st.prot[RANGE_SEL_BIT]);
    next_st.lock_en[5] = st.prot[CL_STUCK_BIT];
    next_st.lock_en[4] = st.prot[OL_STUCK_BIT];
    next_st.lock_en[3] = st.prot[NO_MOTOR_BIT];
    next_st.lock_en[2] = st.prot[KT_FAULT_BIT];
    next_st.lock_en[1] = st.prot[SPD_FAULT_BIT];
    next_st.lock_en[0] = st.prot[LOCK_ILIM_BIT];
    next_st.spd_type = st.drive[SPEED_TYPE_BIT];
    next_st.pwm_khz = st.drive[PWM_RATE_BIT] ? PWM_50K : PWM_25K;
    next_st.kt_hi = st.drive[KT_BOUNDS_LO] ? KT_HI_2 : KT_HI_3_2;
    next_st.kt_hi_w = st.drive[KT_BOUNDS_LO] ? KT_HI_2W : {1'b0, KT_HI_3_2};
    next_st.kt_lo = st.drive[KT_BOUNDS_HI] ? KT_LO_1_2 : KT_LO_3_4;
    next_st.ind_sg = st.drive[IND_SURGE_BIT];
    next_st.mech_sg = st.drive[MECH_SURGE_BIT];
    next_st.mech_ref = st.drive[MECH_REF_BIT];
    next_st.rel = st.drive[SENSE_REL_BIT] ? MPDC_HIZ : MPDC_BRAKE;
    next_st.closed = at_open_to_closed_speed &&
                     !st.drive[CL_INHIBIT_BIT];
    next_st.accel = st.drive[ACCEL_HI:ACCEL_LO];
    next_st.duty = duty_calc;
    next_st.slew = slew_f(st.drive[SLEW_HI:SLEW_LO]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.rel <= MPDC_BRAKE;
      st.pwm_khz <= PWM_25K;
      st.kt_hi <= KT_HI_3_2;
      st.kt_hi_w <= {1'b0, KT_HI_3_2};
      st.kt_lo <= KT_LO_3_4;
      st.lock_thr <= LOCK_2A5;
      st.slew <= SLEW_35;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign current_limit = st.cur_lim;
  assign soft_limit_active = st.soft_act;
  assign lock_current_threshold = st.lock_thr;
  assign lock_detect_en = st.lock_en;
  assign speed_input_type = st.spd_type;
  assign output_pwm_khz = st.pwm_khz;
  assign kt_high_q = st.kt_hi;
  assign kt_high_wide = st.kt_hi_w;
  assign kt_low_q = st.kt_lo;
  assign inductive_surge_guard_en = st.ind_sg;
  assign mechanical_surge_guard_en = st.mech_sg;
  assign mechanical_surge_reference = st.mech_ref;
  assign sense_release_behaviour = st.rel;
  assign enter_closed_loop = st.closed;
  assign closed_loop_acceleration = st.accel;
  assign duty_out = st.duty;
  assign phase_edge_speed = st.slew;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_write_prot;
    reg_wr && reg_addr == PROT_LIMIT_OFS;
  endsequence
  sequence s_read_back;
    ##1 reg_rd && reg_addr == PROT_LIMIT_OFS && !reg_wr ##1 1'b1;
  endsequence

  property p_prot_readback;
    @(posedge clk) disable iff (!reset_n)
      (s_write_prot ##0 s_read_back) |->
        reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_prot_readback: assert property (p_prot_readback)
    else $error("protection register readback mismatch");

  property p_unmapped_zero;
    @(posedge clk) disable iff (!reset_n)
      (reg_rd && reg_addr != PROT_LIMIT_OFS && reg_addr != DRIVE_MODE_OFS)
        |=> reg_rdata == 16'h0000 && reg_rvalid;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_lock_en;
    @(posedge clk) disable iff (!reset_n)
      ##1 lock_detect_en == $past(st.prot[13:8]);
  endproperty
  a_lock_en: assert property (p_lock_en)
    else $error("lock enables do not follow register");

  property p_soft_limit;
    @(posedge clk) disable iff (!reset_n)
      !overtemp_warning |=>
        current_limit == 6'($past(st.prot[7:4]) * 2);
  endproperty
  a_soft_limit: assert property (p_soft_limit)
    else $error("soft current limit wrong");

  property p_ot_cap;
    @(posedge clk) disable iff (!reset_n)
      (overtemp_warning && st.prot[15:14] == 2'b10 && st.prot[7:4] == 4'h0)
        |=> current_limit == 6'h10;
  endproperty
  a_ot_cap: assert property (p_ot_cap)
    else $error("overtemp cap not 1.6 A");

  property p_lock_range1;
    @(posedge clk) disable iff (!reset_n)
      st.prot[0] |=> lock_current_threshold ==
        6'(($past(st.prot[3:1]) + 4'h1) * 4);
  endproperty
  a_lock_range1: assert property (p_lock_range1)
    else $error("range one lock threshold wrong");

  property p_lock_range0;
    @(posedge clk) disable iff (!reset_n)
      (!st.prot[0] && st.prot[2:1] == 2'b11) |=>
        lock_current_threshold == 6'h09;
  endproperty
  a_lock_range0: assert property (p_lock_range0)
    else $error("range zero lock threshold wrong");

  property p_closed_inhibit;
    @(posedge clk) disable iff (!reset_n)
      st.drive[7] |=> !enter_closed_loop;
  endproperty
  a_closed_inhibit: assert property (p_closed_inhibit)
    else $error("closed loop entered while inhibited");

  property p_duty_low;
    @(posedge clk) disable iff (!reset_n)
      (duty_cmd < 8'h03) |=>
        duty_out == ($past(st.drive[3]) ? 8'hC8 : 8'h00);
  endproperty
  a_duty_low: assert property (p_duty_low)
    else $error("duty below cutoff wrong");

  property p_duty_floor;
    @(posedge clk) disable iff (!reset_n)
      (duty_cmd >= 8'h03 && duty_cmd < 8'h0A) |=> duty_out >= 8'h0A;
  endproperty
  a_duty_floor: assert property (p_duty_floor)
    else $error("duty under floor");

  property p_pwm_rate;
    @(posedge clk) disable iff (!reset_n)
      st.drive[14] |=> output_pwm_khz == 6'h32;
  endproperty
  a_pwm_rate: assert property (p_pwm_rate)
    else $error("pwm rate not 50 kHz");

  property p_slew_max;
    @(posedge clk) disable iff (!reset_n)
      st.drive[1:0] == 2'b11 |=> phase_edge_speed == 7'h78;
  endproperty
  a_slew_max: assert property (p_slew_max)
    else $error("slew top code wrong");

  property p_speed_type;
    @(posedge clk) disable iff (!reset_n)
      ##1 speed_input_type == $past(st.drive[15]);
  endproperty
  a_speed_type: assert property (p_speed_type)
    else $error("speed input type does not follow register");

  property p_kt_bounds;
    @(posedge clk) disable iff (!reset_n)
      st.drive[13:12] == 2'b11 |=>
        kt_high_wide == 4'h8 && kt_low_q == 3'h2;
  endproperty
  a_kt_bounds: assert property (p_kt_bounds)
    else $error("torque constant bounds wrong");

  property p_surge;
    @(posedge clk) disable iff (!reset_n)
      ##1 {inductive_surge_guard_en, mechanical_surge_guard_en,
           mechanical_surge_reference} == $past(st.drive[11:9]);
  endproperty
  a_surge: assert property (p_surge)
    else $error("surge guard controls do not follow register");

  property p_release_hiz;
    @(posedge clk) disable iff (!reset_n)
      st.drive[8] |=> sense_release_behaviour == MPDC_HIZ;
  endproperty
  a_release_hiz: assert property (p_release_hiz)
    else $error("release behaviour not high impedance");

  property p_accel;
    @(posedge clk) disable iff (!reset_n)
      ##1 closed_loop_acceleration == $past(st.drive[6:4]);
  endproperty
  a_accel: assert property (p_accel)
    else $error("acceleration field does not follow register");
endmodule

// >>> include/mpdc_pkg.sv
package mpdc_pkg;
  localparam logic [7:0] PROT_LIMIT_OFS = 8'h94;
  localparam logic [7:0] DRIVE_MODE_OFS = 8'h95;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // protection_limit_config fields
  localparam int OT_CAP_HI = 15;
  localparam int OT_CAP_LO = 14;
  localparam int CL_STUCK_BIT = 13;
  localparam int OL_STUCK_BIT = 12;
  localparam int NO_MOTOR_BIT = 11;
  localparam int KT_FAULT_BIT = 10;
  localparam int SPD_FAULT_BIT = 9;
  localparam int LOCK_ILIM_BIT = 8;
  localparam int SOFT_LIM_HI = 7;
  localparam int SOFT_LIM_LO = 4;
  localparam int LOCK_THR_HI = 3;
  localparam int LOCK_THR_LO = 1;
  localparam int RANGE_SEL_BIT = 0;
  // drive_mode_config fields
  localparam int SPEED_TYPE_BIT = 15;
  localparam int PWM_RATE_BIT = 14;
  localparam int KT_BOUNDS_HI = 13;
  localparam int KT_BOUNDS_LO = 12;
  localparam int IND_SURGE_BIT = 11;
  localparam int MECH_SURGE_BIT = 10;
  localparam int MECH_REF_BIT = 9;
  localparam int SENSE_REL_BIT = 8;
  localparam int CL_INHIBIT_BIT = 7;
  localparam int ACCEL_HI = 6;
  localparam int ACCEL_LO = 4;
  localparam int DUTY_POL_HI = 3;
  localparam int DUTY_POL_LO = 2;
  localparam int SLEW_HI = 1;
  localparam int SLEW_LO = 0;
  // current codes in units of 0.1 A
  localparam logic [5:0] CUR_STEP_SOFT = 6'h02;
  localparam logic [5:0] CUR_STEP_LOCK = 6'h04;
  localparam logic [5:0] OT_CAP_1A = 6'h0A;
  localparam logic [5:0] OT_CAP_1A6 = 6'h10;
  localparam logic [5:0] OT_CAP_2A = 6'h14;
  localparam logic [5:0] LOCK_2A5 = 6'h19;
  localparam logic [5:0] LOCK_1A9 = 6'h13;
  localparam logic [5:0] LOCK_1A5 = 6'h0F;
  localparam logic [5:0] LOCK_0A9 = 6'h09;
  // duty in units of 0.5 percent
  localparam logic [7:0] DUTY_FLOOR_5 = 8'h0A;
  localparam logic [7:0] DUTY_FLOOR_10 = 8'h14;
  localparam logic [7:0] DUTY_CUTOFF = 8'h03;
  localparam logic [7:0] DUTY_FULL = 8'hC8;
  // torque constant bounds in quarters of nominal, except KT_HI_2, which holds 0 (8 does not fit in 3 bits)
  localparam logic [2:0] KT_HI_3_2 = 3'h6;
  localparam logic [2:0] KT_HI_2 = 3'h0;
  localparam logic [3:0] KT_HI_2W = 4'h8;
  localparam logic [2:0] KT_LO_3_4 = 3'h3;
  localparam logic [2:0] KT_LO_1_2 = 3'h2;
  // slew in V/us at 12 V
  localparam logic [6:0] SLEW_35 = 7'h23;
  localparam logic [6:0] SLEW_50 = 7'h32;
  localparam logic [6:0] SLEW_80 = 7'h50;
  localparam logic [6:0] SLEW_120 = 7'h78;
  localparam logic [5:0] PWM_25K = 6'h19;
  localparam logic [5:0] PWM_50K = 6'h32;
  typedef enum logic [1:0] {
    MPDC_BRAKE = 2'b00,
    MPDC_HIZ = 2'b01
  } mpdc_release_t;
endpackage

// >>> design/mpdc_duty_floor.sv
`timescale 1ns/1ps
// applies the minimum duty policy to a duty command (units of 0.5 %)
module mpdc_duty_floor (
  input wire logic [1:0] policy,
  input wire logic [7:0] duty_cmd,
  output logic [7:0] duty_out
);
  import mpdc_pkg::*;
  logic [7:0] floor_val;
  always_comb begin
    floor_val = policy[0] ? DUTY_FLOOR_10 : DUTY_FLOOR_5;
    if (duty_cmd < DUTY_CUTOFF) begin
      duty_out = policy[1] ? DUTY_FULL : 8'h00;
    end else if (duty_cmd < floor_val) begin
      duty_out = floor_val;
    end else begin
      duty_out = duty_cmd;
    end
  end
endmodule

// >>> verification/mpdc_host.sv
`timescale 1ns/1ps
// host side of the register strobes: one request per xfer call, a write then a read per wr_rd call, each held for one edge
module mpdc_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // released address and data show the inverse of the last value, so a
  // decode that ignores the strobes cannot pass on a stale match
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                      input logic w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // a write and a read of one offset on consecutive edges
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~d;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// >>> verification/motor_protection_drive_config_bench.sv
`timescale 1ns/1ps
module motor_protection_drive_config_bench;
  import mpdc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic overtemp_warning = 1'b0;
  logic [7:0] duty_cmd = 8'h00;
  logic at_speed = 1'b0;
  logic [5:0] current_limit;
  logic [5:0] lock_thr;
  logic [5:0] lock_detect_en;
  logic speed_type;
  logic [5:0] pwm_khz;
  logic [3:0] kt_high_wide;
  logic [2:0] kt_low_q;
  logic [2:0] kt_high_q;
  logic soft_active;
  wire logic [2:0] surge;
  mpdc_release_t release_mode;
  logic enter_closed_loop;
  logic [2:0] accel;
  logic [7:0] duty_out;
  logic [6:0] edge_speed;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] rd_q[$];
  logic [31:0] seed = 32'h28E719EB;
  logic [15:0] prot = 16'h0000;
  logic [15:0] drv = 16'h0000;

  always #10 clk = ~clk;

  mpdc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  mpdc_config_regs uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .overtemp_warning(overtemp_warning), .duty_cmd(duty_cmd),
    .at_open_to_closed_speed(at_speed), .current_limit(current_limit),
    .soft_limit_active(soft_active), .lock_current_threshold(lock_thr),
    .lock_detect_en(lock_detect_en), .speed_input_type(speed_type),
    .output_pwm_khz(pwm_khz), .kt_high_q(kt_high_q),
    .kt_high_wide(kt_high_wide),
    .kt_low_q(kt_low_q), .inductive_surge_guard_en(surge[2]),
    .mechanical_surge_guard_en(surge[1]),
    .mechanical_surge_reference(surge[0]),
    .sense_release_behaviour(release_mode),
    .enter_closed_loop(enter_closed_loop),
    .closed_loop_acceleration(accel), .duty_out(duty_out),
    .phase_edge_speed(edge_speed));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    host.xfer(a, ~e, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // read data is matched in issue order; an answer with no note is an error
  // sampled on the falling edge, where the registered answer has settled
  always @(negedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end else if (reg_rvalid === 1'b1) begin
      if (rd_q.size() > 0)
        chk(reg_rdata, rd_q.pop_front());
      else
        chk(16'h0001, 16'h0000);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check_outputs();
    logic [5:0] lim;
    logic [5:0] cap;
    logic [5:0] thr;
    logic [7:0] flr;
    logic [7:0] duty_e;
    logic [6:0] slew;
    lim = {2'b00, prot[7:4]} * 6'h02;
    case (prot[15:14])
      2'b01: cap = 6'h0A;
      2'b10: cap = 6'h10;
      2'b11: cap = 6'h14;
      default: cap = 6'h00;
    endcase
    if (overtemp_warning && cap != 0 && (lim == 0 || cap < lim))
      lim = cap;
    if (prot[0])
      thr = ({3'b000, prot[3:1]} + 6'h01) * 6'h04;
    else
      case (prot[2:1])
        2'b00: thr = 6'h19;
        2'b01: thr = 6'h13;
        2'b10: thr = 6'h0F;
        default: thr = 6'h09;
      endcase
    flr = drv[2] ? 8'h14 : 8'h0A;
    if (duty_cmd < 8'h03)
      duty_e = drv[3] ? 8'hC8 : 8'h00;
    else if (duty_cmd < flr)
      duty_e = flr;
    else
      duty_e = duty_cmd;
    case (drv[1:0])
      2'b00: slew = 7'h23;
      2'b01: slew = 7'h32;
      2'b10: slew = 7'h50;
      default: slew = 7'h78;
    endcase
    chk(current_limit, lim);
    chk(soft_active, prot[7:4] != 4'h0);
    chk(lock_thr, thr);
    chk(lock_detect_en[5], prot[13]);
    chk(lock_detect_en[4], prot[12]);
    chk(lock_detect_en[3], prot[11]);
    chk(lock_detect_en[2], prot[10]);
    chk(lock_detect_en[1], prot[9]);
    chk(lock_detect_en[0], prot[8]);
    chk(speed_type, drv[15]);
    chk(pwm_khz, drv[14] ? 6'h32 : 6'h19);
    chk(kt_high_wide, drv[12] ? 4'h8 : 4'h6);
    chk(kt_high_q, drv[12] ? KT_HI_2 : KT_HI_3_2);
    chk(kt_low_q, drv[13] ? 3'h2 : 3'h3);
    chk(surge, drv[11:9]);
    chk(release_mode, {1'b0, drv[8]});
    chk(enter_closed_loop, !drv[7] && at_speed);
    chk(accel, drv[6:4]);
    chk(duty_out, duty_e);
    chk(edge_speed, slew);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] w;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(PROT_LIMIT_OFS, CFG_RESET);
    rd(DRIVE_MODE_OFS, CFG_RESET);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_outputs();
    for (int i = 0; i < 200; i++) begin
      // a reset in mid-run must clear values written before it
      if (i == 100) begin
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        rd(PROT_LIMIT_OFS, CFG_RESET);
        rd(DRIVE_MODE_OFS, CFG_RESET);
      end
      w = xorshift();
      prot = w[15:0];
      drv = w[31:16];
      // some passes leave only the overtemp cap to limit the current
      if (i % 16 == 0) begin
        prot[15:14] = 2'b10;
        prot[7:4] = 4'h0;
      end
      rd_q.push_back(prot);
      host.wr_rd(PROT_LIMIT_OFS, prot);
      host.xfer(DRIVE_MODE_OFS, drv, 1'b1);
      host.xfer(8'h96, ~prot, 1'b1);
      rd(8'h93, 16'h0000);
      rd(PROT_LIMIT_OFS, prot);
      rd(DRIVE_MODE_OFS, drv);
      w = xorshift();
      // small commands half the time so the floor and cutoff edges are hit
      duty_cmd <= w[0] ? {3'b000, w[5:1]} : w[15:8];
      overtemp_warning <= w[16];
      at_speed <= w[17];
      repeat (2) @(posedge clk);
      @(negedge clk);
      check_outputs();
    end
    repeat (4) @(posedge clk);
    chk(16'(rd_q.size()), 16'h0000);
    results();
  end
endmodule
